// ---- core/accel_upper_register_map.sv ----
/*
  upper register bank (2bh..ffh) of the accelerometer: storage, read
  mux, auto-increment pointer, temperature capture and debounce clears.
  assumes: a serial front end on the same clock hands over one address
  byte, write bytes and read-byte requests, plus a stop pulse in i2c
  mode; the operating state and temperature samples come from the
  sensing core on the same clock.
  no input is resynchronised here, so every one of them must already
  be launched from flops on i_ref_clk.
*/
`timescale 1ns/1ps
`include "accel_regs_consts.svh"

// How it works
// - going active to standby leaves every register as it stood.
// - going standby to active returns marked contents to their defaults.
// - threshold and count writes work in any state and clear debounce.
// - the pointer advances only on burst reads, i2c or spi alike.
// - an i2c stop condition sends the pointer back to zero.
// - in spi mode the pointer survives between transactions.
// - temperature result is read-only, eight bits, with no successor.
// - temperature sensor control is read-write, default zero.
// - burst reads step by one from 5fh through the reference bytes.
// - x, y, z trim registers at 2fh, 30h, 31h, default zero.
// - interrupt enable at 2dh, pin routing at 2eh.
// - fall-motion thresholds in high/low pairs from 73h to 78h.
module accel_upper_register_map (
  input logic i_ref_clk,
  input logic i_rst_n,
  input accel_regs_pkg::access_t i_access,
  input logic i_spi_mode,
  input logic i_active,
  input logic i_temp_valid,
  input logic [7:0] i_temp_sample,
  output accel_regs_pkg::cfg_t o_cfg,
  output logic [7:0] o_temperature_result,
  output logic [7:0] o_read_data,
  output logic o_read_valid,
  output logic [7:0] o_pointer,
  output logic o_vecmag_debounce_clear,
  output logic o_fallmotion_debounce_clear
);

  accel_regs_pkg::state_t state;
  accel_regs_pkg::state_t next_state;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  function automatic logic [7:0] read_reg(
    input accel_regs_pkg::cfg_t c,
    input logic [7:0] temp,
    input logic [7:0] a
  );
    logic [7:0] v;
    v = `UNMAPPED_READ_VALUE;
    // unmapped and reserved offsets read back as zero
    unique case (a)
      // control and interrupt routing
      `OFS_SYSTEM_CONTROL_TWO: begin
        v = c.system_control_two;
      end
      `OFS_SYSTEM_CONTROL_THREE: begin
        v = c.system_control_three;
      end
      `OFS_INTERRUPT_ENABLE: begin
        v = c.interrupt_enable;
      end
      `OFS_INTERRUPT_PIN_ROUTING: begin
        v = c.interrupt_pin_routing;
      end

      // per-axis trim
      `OFS_X_AXIS_TRIM: begin
        v = c.x_axis_trim;
      end
      `OFS_Y_AXIS_TRIM: begin
        v = c.y_axis_trim;
      end
      `OFS_Z_AXIS_TRIM: begin
        v = c.z_axis_trim;
      end

      // temperature
      `OFS_TEMPERATURE_RESULT: begin
        v = temp;
      end
      `OFS_TEMPERATURE_SENSOR_CONTROL: begin
        v = c.temperature_sensor_control;
      end
      `OFS_TEMPERATURE_BURST_INCLUSION: begin
        v = c.temperature_burst_inclusion;
      end

      // vector magnitude
      `OFS_VECMAG_CONFIGURATION: begin
        v = c.vecmag_configuration;
      end
      `OFS_VECMAG_THRESHOLD_HIGH: begin
        v = c.vecmag_threshold_high;
      end
      `OFS_VECMAG_THRESHOLD_LOW: begin
        v = c.vecmag_threshold_low;
      end
      `OFS_VECMAG_DEBOUNCE_COUNT: begin
        v = c.vecmag_debounce_count;
      end
      `OFS_VECMAG_REF_X_HIGH: begin
        v = c.vecmag_ref_x_high;
      end
      `OFS_VECMAG_REF_X_LOW: begin
        v = c.vecmag_ref_x_low;
      end
      `OFS_VECMAG_REF_Y_HIGH: begin
        v = c.vecmag_ref_y_high;
      end
      `OFS_VECMAG_REF_Y_LOW: begin
        v = c.vecmag_ref_y_low;
      end
      `OFS_VECMAG_REF_Z_HIGH: begin
        v = c.vecmag_ref_z_high;
      end
      `OFS_VECMAG_REF_Z_LOW: begin
        v = c.vecmag_ref_z_low;
      end

      // fall-motion thresholds
      `OFS_FALLMOTION_X_THRESH_HIGH: begin
        v = c.fallmotion_x_thresh_high;
      end
      `OFS_FALLMOTION_X_THRESH_LOW: begin
        v = c.fallmotion_x_thresh_low;
      end
      `OFS_FALLMOTION_Y_THRESH_HIGH: begin
        v = c.fallmotion_y_thresh_high;
      end
      `OFS_FALLMOTION_Y_THRESH_LOW: begin
        v = c.fallmotion_y_thresh_low;
      end
      `OFS_FALLMOTION_Z_THRESH_HIGH: begin
        v = c.fallmotion_z_thresh_high;
      end
      `OFS_FALLMOTION_Z_THRESH_LOW: begin
        v = c.fallmotion_z_thresh_low;
      end
      default: v = `UNMAPPED_READ_VALUE;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // auto-increment successor
  // ---------------------------------------------------------------
  // the temperature result has no successor, so a burst parks on it
  // a burst from ffh wraps round to 00h
  function automatic logic [7:0] next_addr(input logic [7:0] a);
    logic [7:0] n;
    n = a + `POINTER_STEP;
    if (a == `OFS_TEMPERATURE_RESULT) begin
      n = a;
    end
    return n;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.read_valid = 1'b0;
    next_state.vecmag_debounce_clear = 1'b0;
    next_state.fallmotion_debounce_clear = 1'b0;
    next_state.active_seen = i_active;

    // -------------------------------------------------------------
    // temperature capture
    // -------------------------------------------------------------
    // a sample lands only while the sensor enable bit is set
    if (i_temp_valid &&
        state.cfg.temperature_sensor_control[`TEMP_ENABLE_BIT]) begin
      next_state.temperature_result = i_temp_sample;
    end

    // -------------------------------------------------------------
    // operating state change
    // -------------------------------------------------------------
    // going standby to active: marked contents back to default
    if (i_active && !state.active_seen) begin
      next_state.temperature_result = `TEMP_RESET_VALUE;
    end
    // going active to standby: nothing is touched here, contents stay

    // -------------------------------------------------------------
    // host access
    // -------------------------------------------------------------
    // one access per cycle: address beats read, read beats write
    // address phase loads the pointer (eight-bit decode)
    if (i_access.addr_valid) begin
      next_state.pointer = i_access.addr;
    end else if (i_access.read_take) begin
      next_state.read_data = read_reg(state.cfg, state.temperature_result,
                                      state.pointer);
      next_state.read_valid = 1'b1;
      if (i_access.burst) begin
        next_state.pointer = next_addr(state.pointer);
      end
    end else if (i_access.write_valid) begin
      // writes never advance the pointer; reserved offsets are ignored
      unique case (state.pointer)
        // control and interrupt routing
        `OFS_SYSTEM_CONTROL_TWO: begin
          next_state.cfg.system_control_two = i_access.write_data;
        end
        `OFS_SYSTEM_CONTROL_THREE: begin
          next_state.cfg.system_control_three = i_access.write_data;
        end
        `OFS_INTERRUPT_ENABLE: begin
          next_state.cfg.interrupt_enable = i_access.write_data;
        end
        `OFS_INTERRUPT_PIN_ROUTING: begin
          next_state.cfg.interrupt_pin_routing = i_access.write_data;
        end

        // per-axis trim
        `OFS_X_AXIS_TRIM: begin
          next_state.cfg.x_axis_trim = i_access.write_data;
        end
        `OFS_Y_AXIS_TRIM: begin
          next_state.cfg.y_axis_trim = i_access.write_data;
        end
        `OFS_Z_AXIS_TRIM: begin
          next_state.cfg.z_axis_trim = i_access.write_data;
        end

        // temperature
        `OFS_TEMPERATURE_SENSOR_CONTROL: begin
          next_state.cfg.temperature_sensor_control =
            i_access.write_data;
        end
        `OFS_TEMPERATURE_BURST_INCLUSION: begin
          next_state.cfg.temperature_burst_inclusion = i_access.write_data;
        end

        // vector magnitude
        `OFS_VECMAG_CONFIGURATION: begin
          next_state.cfg.vecmag_configuration = i_access.write_data;
        end
        `OFS_VECMAG_THRESHOLD_HIGH: begin
          next_state.cfg.vecmag_threshold_high = i_access.write_data;
          next_state.vecmag_debounce_clear = 1'b1;
        end
        `OFS_VECMAG_THRESHOLD_LOW: begin
          next_state.cfg.vecmag_threshold_low = i_access.write_data;
          next_state.vecmag_debounce_clear = 1'b1;
        end
        `OFS_VECMAG_DEBOUNCE_COUNT: begin
          next_state.cfg.vecmag_debounce_count = i_access.write_data;
          next_state.vecmag_debounce_clear = 1'b1;
        end
        `OFS_VECMAG_REF_X_HIGH: begin
          next_state.cfg.vecmag_ref_x_high = i_access.write_data;
        end
        `OFS_VECMAG_REF_X_LOW: begin
          next_state.cfg.vecmag_ref_x_low = i_access.write_data;
        end
        `OFS_VECMAG_REF_Y_HIGH: begin
          next_state.cfg.vecmag_ref_y_high = i_access.write_data;
        end
        `OFS_VECMAG_REF_Y_LOW: begin
          next_state.cfg.vecmag_ref_y_low = i_access.write_data;
        end
        `OFS_VECMAG_REF_Z_HIGH: begin
          next_state.cfg.vecmag_ref_z_high = i_access.write_data;
        end
        `OFS_VECMAG_REF_Z_LOW: begin
          next_state.cfg.vecmag_ref_z_low = i_access.write_data;
        end

        // fall-motion thresholds
        `OFS_FALLMOTION_X_THRESH_HIGH: begin
          next_state.cfg.fallmotion_x_thresh_high = i_access.write_data;
          next_state.fallmotion_debounce_clear = 1'b1;
        end
        `OFS_FALLMOTION_X_THRESH_LOW: begin
          next_state.cfg.fallmotion_x_thresh_low = i_access.write_data;
          next_state.fallmotion_debounce_clear = 1'b1;
        end
        `OFS_FALLMOTION_Y_THRESH_HIGH: begin
          next_state.cfg.fallmotion_y_thresh_high = i_access.write_data;
          next_state.fallmotion_debounce_clear = 1'b1;
        end
        `OFS_FALLMOTION_Y_THRESH_LOW: begin
          next_state.cfg.fallmotion_y_thresh_low = i_access.write_data;
          next_state.fallmotion_debounce_clear = 1'b1;
        end
        `OFS_FALLMOTION_Z_THRESH_HIGH: begin
          next_state.cfg.fallmotion_z_thresh_high = i_access.write_data;
          next_state.fallmotion_debounce_clear = 1'b1;
        end
        `OFS_FALLMOTION_Z_THRESH_LOW: begin
          next_state.cfg.fallmotion_z_thresh_low = i_access.write_data;
          next_state.fallmotion_debounce_clear = 1'b1;
        end
        default: begin
          // reserved, unmapped and read-only offsets are ignored
          next_state.cfg = state.cfg;
        end
      endcase
    end

    // -------------------------------------------------------------
    // stop handling
    // -------------------------------------------------------------
    // i2c stop homes the pointer; spi has no stop and keeps it
    if (i_access.stop_seen && !i_spi_mode) begin
      next_state.pointer = `POINTER_HOME;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign o_cfg = state.cfg;
  assign o_temperature_result = state.temperature_result;
  assign o_read_data = state.read_data;
  assign o_read_valid = state.read_valid;
  assign o_pointer = state.pointer;
  assign o_vecmag_debounce_clear = state.vecmag_debounce_clear;
  assign o_fallmotion_debounce_clear = state.fallmotion_debounce_clear;

endmodule

// ---- core/accel_regs_consts.svh ----
/*
  register offsets, reset values and pointer constants for the upper
  register bank of the accelerometer.
  assumes: included by the bank module only.
*/
`ifndef ACCEL_REGS_CONSTS_SVH
`define ACCEL_REGS_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_SYSTEM_CONTROL_TWO 8'h2b
`define OFS_SYSTEM_CONTROL_THREE 8'h2c
`define OFS_INTERRUPT_ENABLE 8'h2d
`define OFS_INTERRUPT_PIN_ROUTING 8'h2e
`define OFS_X_AXIS_TRIM 8'h2f
`define OFS_Y_AXIS_TRIM 8'h30
`define OFS_Z_AXIS_TRIM 8'h31
`define OFS_TEMPERATURE_RESULT 8'h51
`define OFS_TEMPERATURE_SENSOR_CONTROL 8'h5b
`define OFS_TEMPERATURE_BURST_INCLUSION 8'h5c
`define OFS_VECMAG_CONFIGURATION 8'h5f
`define OFS_VECMAG_THRESHOLD_HIGH 8'h60
`define OFS_VECMAG_THRESHOLD_LOW 8'h61
`define OFS_VECMAG_DEBOUNCE_COUNT 8'h62
`define OFS_VECMAG_REF_X_HIGH 8'h63
`define OFS_VECMAG_REF_X_LOW 8'h64
`define OFS_VECMAG_REF_Y_HIGH 8'h65
`define OFS_VECMAG_REF_Y_LOW 8'h66
`define OFS_VECMAG_REF_Z_HIGH 8'h67
`define OFS_VECMAG_REF_Z_LOW 8'h68
`define OFS_FALLMOTION_X_THRESH_HIGH 8'h73
`define OFS_FALLMOTION_X_THRESH_LOW 8'h74
`define OFS_FALLMOTION_Y_THRESH_HIGH 8'h75
`define OFS_FALLMOTION_Y_THRESH_LOW 8'h76
`define OFS_FALLMOTION_Z_THRESH_HIGH 8'h77
`define OFS_FALLMOTION_Z_THRESH_LOW 8'h78

// ---------------------------------------------------------------
// reset values and pointer constants
// ---------------------------------------------------------------
`define REG_RESET_VALUE 8'h00
`define TEMP_RESET_VALUE 8'h00
`define POINTER_HOME 8'h00
`define POINTER_STEP 8'h01
`define TEMP_ENABLE_BIT 0
`define UNMAPPED_READ_VALUE 8'h00

`endif

// ---- core/accel_regs_pkg.sv ----
/*
  types shared by the upper register bank and its surroundings.
  assumes: nothing beyond the constants header.
*/
package accel_regs_pkg;

  // ---------------------------------------------------------------
  // software-visible configuration
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] system_control_two;
    logic [7:0] system_control_three;
    logic [7:0] interrupt_enable;
    logic [7:0] interrupt_pin_routing;
    logic [7:0] x_axis_trim;
    logic [7:0] y_axis_trim;
    logic [7:0] z_axis_trim;
    logic [7:0] temperature_sensor_control;
    logic [7:0] temperature_burst_inclusion;
    logic [7:0] vecmag_configuration;
    logic [7:0] vecmag_threshold_high;
    logic [7:0] vecmag_threshold_low;
    logic [7:0] vecmag_debounce_count;
    logic [7:0] vecmag_ref_x_high;
    logic [7:0] vecmag_ref_x_low;
    logic [7:0] vecmag_ref_y_high;
    logic [7:0] vecmag_ref_y_low;
    logic [7:0] vecmag_ref_z_high;
    logic [7:0] vecmag_ref_z_low;
    logic [7:0] fallmotion_x_thresh_high;
    logic [7:0] fallmotion_x_thresh_low;
    logic [7:0] fallmotion_y_thresh_high;
    logic [7:0] fallmotion_y_thresh_low;
    logic [7:0] fallmotion_z_thresh_high;
    logic [7:0] fallmotion_z_thresh_low;
  } cfg_t;

  // ---------------------------------------------------------------
  // byte access from the serial front end
  // ---------------------------------------------------------------
  typedef struct packed {
    logic addr_valid;
    logic [7:0] addr;
    logic write_valid;
    logic [7:0] write_data;
    logic read_take;
    logic burst;
    logic stop_seen;
  } access_t;

  // ---------------------------------------------------------------
  // whole state of the bank
  // ---------------------------------------------------------------
  typedef struct packed {
    cfg_t cfg;
    logic [7:0] temperature_result;
    logic [7:0] pointer;
    logic [7:0] read_data;
    logic read_valid;
    logic active_seen;
    logic vecmag_debounce_clear;
    logic fallmotion_debounce_clear;
  } state_t;

endpackage

// ---- sim/accel_regs_checker.sv ----
/* assertions on the ports of the upper register bank.
   assumes: bound to accel_upper_register_map, one clock. */
`timescale 1ns/1ps
module accel_regs_checker (
  input logic i_ref_clk,
  input logic i_rst_n,
  input accel_regs_pkg::access_t i_access,
  input logic i_spi_mode,
  input logic i_active,
  input logic i_temp_valid,
  input logic [7:0] i_temp_sample,
  input accel_regs_pkg::cfg_t o_cfg,
  input logic [7:0] o_temperature_result,
  input logic [7:0] o_read_data,
  input logic o_read_valid,
  input logic [7:0] o_pointer,
  input logic o_vecmag_debounce_clear,
  input logic o_fallmotion_debounce_clear
);
  logic take_rd;
  logic take_wr;
  logic stop_i2c;
  logic [7:0] p;
  assign p = o_pointer;
  assign take_rd = i_access.read_take && !i_access.addr_valid;
  assign take_wr = i_access.write_valid && !i_access.addr_valid &&
    !i_access.read_take;
  assign stop_i2c = i_access.stop_seen && !i_spi_mode;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_read_answer:
    assert property (o_read_valid == $past(take_rd))
    else $error("read valid not one cycle after request");
  a_burst_step:
    assert property (take_rd && i_access.burst && !stop_i2c && p != 8'h51
      |=> p == $past(p) + 8'h01) else $error("burst pointer did not step");
  a_temp_no_successor:
    assert property (take_rd && i_access.burst && !stop_i2c && p == 8'h51
      |=> p == 8'h51) else $error("pointer left temperature result");
  a_single_read_hold:
    assert property (take_rd && !i_access.burst && !stop_i2c |=> $stable(p))
    else $error("pointer moved on a single read");
  a_stop_home:
    assert property (stop_i2c && !i_access.addr_valid |=> p == 8'h00)
    else $error("i2c stop did not home the pointer");
  a_spi_keeps:
    assert property (i_access.stop_seen && i_spi_mode && !i_access.addr_valid
      && !i_access.read_take |=> $stable(p)) else $error("spi pointer lost");
  a_vecmag_clear:
    assert property (take_wr && p inside {[8'h60:8'h62]}
      |=> o_vecmag_debounce_clear) else $error("no vecmag debounce clear");
  a_fall_clear:
    assert property (take_wr && p inside {[8'h73:8'h78]}
      |=> o_fallmotion_debounce_clear) else $error("no fall debounce clear");
  a_temp_readonly:
    assert property (take_wr && p == 8'h51 && !i_temp_valid && !i_active
      |=> $stable(o_temperature_result)) else $error("temperature written");
  a_active_clear:
    assert property ($rose(i_active) |=> o_temperature_result == 8'h00)
    else $error("temperature not cleared on going active");
  a_temp_gate:
    assert property (i_temp_valid && !o_cfg.temperature_sensor_control[0]
      && $stable(i_active) |=> $stable(o_temperature_result))
    else $error("temperature captured while sensor disabled");
  c_burst: cover property (take_rd && i_access.burst);
  c_spi_burst: cover property (take_rd && i_access.burst && i_spi_mode);
  c_stop: cover property (stop_i2c);
  c_fall: cover property (o_fallmotion_debounce_clear);
endmodule

bind accel_upper_register_map accel_regs_checker chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_access(i_access),
  .i_spi_mode(i_spi_mode), .i_active(i_active),
  .i_temp_valid(i_temp_valid), .i_temp_sample(i_temp_sample),
  .o_cfg(o_cfg), .o_temperature_result(o_temperature_result),
  .o_read_data(o_read_data), .o_read_valid(o_read_valid),
  .o_pointer(o_pointer), .o_vecmag_debounce_clear(o_vecmag_debounce_clear),
  .o_fallmotion_debounce_clear(o_fallmotion_debounce_clear)
);

// ---- sim/host_model.sv ----
/* host side of the serial front end: one byte operation per call.
   assumes: called from the testbench by hierarchical task calls. */
`timescale 1ns/1ps
module host_model (
  input logic i_ref_clk,
  output accel_regs_pkg::access_t o_access
);
  initial o_access = '0;
  // one-cycle request; released addr and write_data lines show the inverse of the last value, the rest go to zero
  task automatic issue(input accel_regs_pkg::access_t c);
    @(negedge i_ref_clk);
    o_access = c;
    @(negedge i_ref_clk);
    o_access = '{addr: ~c.addr, write_data: ~c.write_data, default: '0};
  endtask
  task automatic setp(input logic [7:0] a);
    issue('{addr_valid: 1'b1, addr: a, default: '0});
  endtask
  task automatic wr(input logic [7:0] d);
    issue('{write_valid: 1'b1, write_data: d, default: '0});
  endtask
  task automatic rd(input logic b);
    issue('{read_take: 1'b1, burst: b, default: '0});
  endtask
  task automatic stop_cond;
    issue('{stop_seen: 1'b1, default: '0});
  endtask
endmodule

// ---- sim/testbench.sv ----
/* self-checking bench for the upper register bank.
   assumes: host_model drives the access port; checker is bound. */
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic spi = 1'b0;
  logic act = 1'b0;
  logic tv = 1'b0;
  logic [7:0] ts = 8'h00;
  logic [7:0] temp, rdata, ptr, exp_temp;
  logic rv, vclr, fclr;
  logic [7:0] mem [0:255];
  accel_regs_pkg::access_t acc;
  accel_regs_pkg::cfg_t cfg;
  int mismatches = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  host_model host (.i_ref_clk(clk), .o_access(acc));
  accel_upper_register_map uut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_access(acc), .i_spi_mode(spi),
    .i_active(act), .i_temp_valid(tv), .i_temp_sample(ts), .o_cfg(cfg),
    .o_temperature_result(temp), .o_read_data(rdata),
    .o_read_valid(rv), .o_pointer(ptr),
    .o_vecmag_debounce_clear(vclr), .o_fallmotion_debounce_clear(fclr)
  );
  function automatic logic is_rw(input logic [7:0] a);
    return a inside {[8'h2b:8'h31], 8'h5b, 8'h5c, [8'h5f:8'h68],
      [8'h73:8'h78]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == 8'h51) return exp_temp;
    return is_rw(a) ? mem[a] : 8'h00;
  endfunction
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    host.setp(a);
    host.wr(d);
    if (is_rw(a)) mem[a] = d;
    check("vec clr", {7'h00, vclr}, 8'(a inside {[8'h60:8'h62]}));
    check("fall clr", {7'h00, fclr}, 8'(a inside {[8'h73:8'h78]}));
  endtask
  // burst walk from 2bh to 7ah, reloading after the non-advancing byte
  task automatic sweep;
    for (int a = 8'h2b; a <= 8'h7a; a++) begin
      if (a == 8'h2b || a == 8'h52) host.setp(8'(a));
      host.rd(1'b1);
      check("valid", {7'h00, rv}, 8'h01);
      check("data", rdata, exp_rd(8'(a)));
      check("pointer", ptr, (a == 8'h51) ? 8'h51 : 8'(a + 1));
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    stop_test;
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    exp_temp = 8'h00;
    void'($urandom(14247));
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    sweep;
    // random contents, written in standby to mapped places only
    for (int a = 8'h2b; a <= 8'h78; a++) begin
      if (is_rw(8'(a))) write_reg(8'(a), 8'($urandom));
    end
    write_reg(8'h5b, 8'h01);
    write_reg(8'h51, 8'h5a);
    ts = 8'($urandom);
    tv = 1'b1;
    @(negedge clk);
    tv = 1'b0;
    exp_temp = ts;
    sweep;
    write_reg(8'h5b, 8'h00);
    ts = ~exp_temp;
    tv = 1'b1;
    @(negedge clk);
    tv = 1'b0;
    check("temp gated", temp, exp_temp);
    act = 1'b1;
    repeat (3) @(negedge clk);
    exp_temp = 8'h00;
    check("temp", temp, exp_temp);
    write_reg(8'h60, 8'($urandom));
    write_reg(8'h73, 8'($urandom));
    check("cfg fall x", cfg.fallmotion_x_thresh_high, mem[8'h73]);
    check("cfg vec hi", cfg.vecmag_threshold_high, mem[8'h60]);
    check("cfg routing", cfg.interrupt_pin_routing, mem[8'h2e]);
    act = 1'b0;
    sweep;
    host.setp(8'h2d);
    host.rd(1'b0);
    check("plain read", ptr, 8'h2d);
    check("plain data", rdata, mem[8'h2d]);
    host.setp(8'h40);
    host.stop_cond;
    check("i2c stop", ptr, 8'h00);
    spi = 1'b1;
    host.setp(8'h40);
    host.stop_cond;
    check("spi stop", ptr, 8'h40);
    host.setp(8'h2f);
    for (int i = 0; i < 3; i++) begin
      host.rd(1'b1);
      check("spi data", rdata, mem[8'h2f + i]);
      check("spi pointer", ptr, 8'(8'h30 + i));
    end
    host.stop_cond;
    check("spi keeps", ptr, 8'h32);
    stop_test;
  end
endmodule
